/* metering_interrupt_enable_tb.sv */
// self-checking bench of the metering interrupt enable block
// assumes mie_pkg, mie_map.svh and the core model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mie_map.svh"
module metering_interrupt_enable_tb;
  logic clk = 1'b0; // core clock
  logic rst = 1'b1; // async reset, high
  logic [21:0] ev = '0; // events laid out as status bits, eight per register
  logic [7:0] addr; // sfr address
  logic wr; // write strobe
  logic rd; // read strobe
  logic [7:0] wdata; // write data
  logic [7:0] rdata; // read data
  logic irq; // pending interrupt
  int err_count = 0; // mismatches
  int n_compared = 0; // comparisons

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  mie_cpu_model i_cpu (.i_core_clk(clk), .o_sfr_addr(addr), .o_sfr_wr(wr), .o_sfr_rd(rd),
    .o_sfr_wdata(wdata), .i_sfr_rdata(rdata));

  mie_core i_dut (.i_core_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd),
    .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_metering_irq(irq),
    .i_fault_channel_change(ev[5]), .i_reactive_sign_change(ev[4]), .i_active_sign_change(ev[3]),
    .i_apparent_no_load(ev[2]), .i_reactive_no_load(ev[1]), .i_active_no_load(ev[0]),
    .i_calib_pulse_two(ev[15]), .i_calib_pulse_one(ev[14]), .i_apparent_energy_overflow(ev[13]),
    .i_reactive_energy_overflow(ev[12]), .i_active_energy_overflow(ev[11]),
    .i_apparent_energy_half(ev[10]), .i_reactive_energy_half(ev[9]), .i_active_energy_half(ev[8]),
    .i_waveform_sample_ready(ev[21]), .i_current_peak_exceeded(ev[20]),
    .i_voltage_peak_exceeded(ev[19]), .i_line_cycle_end(ev[18]), .i_zero_cross_timeout(ev[17]),
    .i_zero_cross_detect(ev[16]));

  // verdict and end of run
  task automatic end_sim();
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // compare one byte and report a difference
  task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one-cycle event pulse
  task automatic pulse(input int idx);
    @(negedge clk);
    ev[idx] = 1'b1;
    @(negedge clk);
    ev[idx] = 1'b0;
  endtask

  // reset values of enables, end-of-reset flag and interrupt
  task automatic t_reset();
    logic [7:0] v;
    chk("irq after reset", {7'h00, irq}, 8'h00);
    for (int r = 0; r < 3; r++) begin
      i_cpu.rd(`MIE_EN_LOW_ADDR + 8'(r), v);
      chk("enable reset", v, 8'h00);
    end
    i_cpu.rd(`MIE_ST_HIGH_ADDR, v);
    chk("end of reset flag", v, 8'h80);
  endtask

  // reserved enable bits, unmapped address
  task automatic t_access();
    logic [7:0] v;
    logic [7:0] exp [3] = '{8'h3F, 8'hFF, 8'h3F};
    for (int r = 0; r < 3; r++) begin
      i_cpu.wr(`MIE_EN_LOW_ADDR + 8'(r), 8'hFF);
      i_cpu.rd(`MIE_EN_LOW_ADDR + 8'(r), v);
      chk("enable readback", v, exp[r]);
      // read data stands for one cycle only
      @(negedge clk);
      chk("read data idle", rdata, 8'h00);
      i_cpu.wr(`MIE_EN_LOW_ADDR + 8'(r), 8'h00);
    end
    i_cpu.wr(8'hD8, 8'hFF);
    i_cpu.rd(8'hD8, v);
    chk("unmapped read", v, 8'h00);
  endtask

  // every source: flagged while masked, raises irq once enabled, drops on clear
  task automatic t_sources();
    logic [7:0] v;
    logic [7:0] m;
    i_cpu.wr(`MIE_ST_HIGH_ADDR, 8'h00);
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < ((r == 1) ? 8 : 6); b++) begin
        m = 8'h01 << b;
        pulse(8 * r + b);
        chk("irq while masked", {7'h00, irq}, 8'h00);
        i_cpu.rd(`MIE_ST_LOW_ADDR + 8'(r), v);
        chk("flag position", v, m);
        i_cpu.wr(`MIE_EN_LOW_ADDR + 8'(r), m);
        @(negedge clk);
        chk("irq enabled", {7'h00, irq}, 8'h01);
        // pending line stays up while the flag is not cleared
        repeat (3) @(negedge clk);
        chk("irq held", {7'h00, irq}, 8'h01);
        i_cpu.rd(`MIE_ST_LOW_ADDR, v);
        chk("summary bit", v & 8'h80, 8'h80);
        i_cpu.wr(`MIE_ST_LOW_ADDR + 8'(r), ~m);
        @(negedge clk);
        chk("irq after clear", {7'h00, irq}, 8'h00);
        i_cpu.wr(`MIE_EN_LOW_ADDR + 8'(r), 8'h00);
      end
    end
  endtask

  // event and clear of the same flag in one cycle: the event wins
  task automatic t_collide();
    logic [7:0] v;
    fork
      i_cpu.wr(`MIE_ST_HIGH_ADDR, 8'hFE);
      pulse(16);
    join
    i_cpu.rd(`MIE_ST_HIGH_ADDR, v);
    chk("event over clear", v, 8'h01);
    i_cpu.wr(`MIE_ST_HIGH_ADDR, 8'hFE);
    i_cpu.rd(`MIE_ST_HIGH_ADDR, v);
    chk("flag cleared", v, 8'h00);
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_access();
    t_sources();
    t_collide();
    end_sim();
  end
endmodule
`default_nettype wire

/* mie_core.sv */
// metering interrupt enable and status logic
// assumes events arrive as one-cycle pulses from
// metering logic on the same clock, and sfr accesses
// from the processor core on that clock as well
//
// Notes on behaviour
// - fault channel flag raises enabled interrupt
// - reactive sign flag raises enabled interrupt
// - active sign flag raises enabled interrupt
// - apparent no-load flag raises enabled interrupt
// - reactive no-load flag raises enabled interrupt
// - active no-load flag raises enabled interrupt
// - second calibration pulse raises enabled interrupt
// - first calibration pulse raises enabled interrupt
// - energy overflow flags raise enabled interrupt
// - energy half-full flags raise enabled interrupt
// - waveform sample flag raises enabled interrupt
// - current and voltage peaks raise interrupt
// - line cycle end raises enabled interrupt
// - zero-cross timeout and detect raise interrupt
// - summary bit follows any enabled set flag
// - calibration flags set even when output off
// - waveform interrupt holds until flag cleared
// - enable bits mirror status bit positions
`include "mie_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mie_core
  import mie_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // sfr access from the processor core
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  // first group of metering events
  input wire logic i_fault_channel_change,
  input wire logic i_reactive_sign_change,
  input wire logic i_active_sign_change,
  input wire logic i_apparent_no_load,
  input wire logic i_reactive_no_load,
  input wire logic i_active_no_load,
  // second group of metering events
  input wire logic i_calib_pulse_two,
  input wire logic i_calib_pulse_one,
  input wire logic i_apparent_energy_overflow,
  input wire logic i_reactive_energy_overflow,
  input wire logic i_active_energy_overflow,
  input wire logic i_apparent_energy_half,
  input wire logic i_reactive_energy_half,
  input wire logic i_active_energy_half,
  // third group of metering events
  input wire logic i_waveform_sample_ready,
  input wire logic i_current_peak_exceeded,
  input wire logic i_voltage_peak_exceeded,
  input wire logic i_line_cycle_end,
  input wire logic i_zero_cross_timeout,
  input wire logic i_zero_cross_detect,
  // pending metering interrupt to the core
  output logic o_metering_irq
);

  // address match, used for every register
  function automatic logic sel(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    sel = (addr == off);
  endfunction

  // registered state and its next value
  mie_state_t st_r;
  mie_state_t st_nxt;

  // event pulses gathered by register
  logic [7:0] ev_low;
  logic [7:0] ev_mid;
  logic [7:0] ev_high;

  // software clear masks per status register
  logic [7:0] clr_low;
  logic [7:0] clr_mid;
  logic [7:0] clr_high;

  // write strobes per register
  logic wr_en_low;
  logic wr_en_mid;
  logic wr_en_high;
  logic wr_st_low;
  logic wr_st_mid;
  logic wr_st_high;

  // events at the bit of their enable
  assign ev_low = {2'b00,
    i_fault_channel_change,
    i_reactive_sign_change,
    i_active_sign_change,
    i_apparent_no_load,
    i_reactive_no_load,
    i_active_no_load};
  assign ev_mid = {
    i_calib_pulse_two,
    i_calib_pulse_one,
    i_apparent_energy_overflow,
    i_reactive_energy_overflow,
    i_active_energy_overflow,
    i_apparent_energy_half,
    i_reactive_energy_half,
    i_active_energy_half};
  assign ev_high = {2'b00,
    i_waveform_sample_ready,
    i_current_peak_exceeded,
    i_voltage_peak_exceeded,
    i_line_cycle_end,
    i_zero_cross_timeout,
    i_zero_cross_detect};

  // address decode of the six registers
  assign wr_en_low = i_sfr_wr && sel(i_sfr_addr, `MIE_EN_LOW_ADDR);
  assign wr_en_mid = i_sfr_wr && sel(i_sfr_addr, `MIE_EN_MID_ADDR);
  assign wr_en_high = i_sfr_wr && sel(i_sfr_addr, `MIE_EN_HIGH_ADDR);
  assign wr_st_low = i_sfr_wr && sel(i_sfr_addr, `MIE_ST_LOW_ADDR);
  assign wr_st_mid = i_sfr_wr && sel(i_sfr_addr, `MIE_ST_MID_ADDR);
  assign wr_st_high = i_sfr_wr && sel(i_sfr_addr, `MIE_ST_HIGH_ADDR);

  // a zero written to a flag clears it
  assign clr_low = wr_st_low ? ~i_sfr_wdata : 8'h00;
  assign clr_mid = wr_st_mid ? ~i_sfr_wdata : 8'h00;
  assign clr_high = wr_st_high ? ~i_sfr_wdata : 8'h00;

  // next state: flags, enables, interrupt, read data
  always_comb begin
    st_nxt = st_r;
    // enables take written data, reserved bits stay zero
    if (wr_en_low) begin
      st_nxt.en_low = i_sfr_wdata & `MIE_EN_LOW_MASK;
    end
    if (wr_en_mid) begin
      st_nxt.en_mid = i_sfr_wdata & `MIE_EN_MID_MASK;
    end
    if (wr_en_high) begin
      st_nxt.en_high = i_sfr_wdata & `MIE_EN_HIGH_MASK;
    end
    // flags: an event wins over a clear in the same cycle
    st_nxt.st_low = ((st_r.st_low & ~clr_low) | ev_low)
      & `MIE_ST_LOW_MASK;
    // calibration pulses set flags whatever the mode
    st_nxt.st_mid = (st_r.st_mid & ~clr_mid) | ev_mid;
    // waveform flag stays until software clears it
    st_nxt.st_high = ((st_r.st_high & ~clr_high) | ev_high)
      & `MIE_ST_HIGH_MASK;
    // one shared pending line from all enabled flags
    st_nxt.irq = |(st_nxt.st_low & st_nxt.en_low)
      | |(st_nxt.st_mid & st_nxt.en_mid)
      | |(st_nxt.st_high & st_nxt.en_high);
    // read data holds the value before any write
    st_nxt.rdata = 8'h00;
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        `MIE_EN_LOW_ADDR: begin
          st_nxt.rdata = st_r.en_low;
        end
        `MIE_EN_MID_ADDR: begin
          st_nxt.rdata = st_r.en_mid;
        end
        `MIE_EN_HIGH_ADDR: begin
          st_nxt.rdata = st_r.en_high;
        end
        `MIE_ST_LOW_ADDR: begin
          // summary bit shows the pending line
          st_nxt.rdata = st_r.st_low;
          st_nxt.rdata[`MIE_SUMMARY_BIT] = st_r.irq;
        end
        `MIE_ST_MID_ADDR: begin
          st_nxt.rdata = st_r.st_mid;
        end
        `MIE_ST_HIGH_ADDR: begin
          st_nxt.rdata = st_r.st_high;
        end
        default: begin
          // other sfr addresses belong elsewhere
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  // state register; enables clear so nothing fires
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r.en_low <= `MIE_EN_RST;
      st_r.en_mid <= `MIE_EN_RST;
      st_r.en_high <= `MIE_EN_RST;
      st_r.st_low <= `MIE_ST_RST;
      st_r.st_mid <= `MIE_ST_RST;
      // end-of-reset flag starts set
      st_r.st_high <= `MIE_ST_HIGH_RST;
      st_r.irq <= 1'b0;
      st_r.rdata <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign o_sfr_rdata = st_r.rdata;
  assign o_metering_irq = st_r.irq;

  // checks on the interrupt behaviour
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // enabled event pulse
  sequence s_fault_ev;
    i_fault_channel_change && st_r.en_low[5] && !wr_en_low;
  endsequence

  // waveform flag pending with nothing clearing it
  sequence s_wave_hold;
    st_r.st_high[`MIE_WAVE_BIT] && st_r.en_high[`MIE_WAVE_BIT]
      && !wr_en_high && !wr_st_high;
  endsequence

  // read of the first status register
  sequence s_sum_rd;
    i_sfr_rd && sel(i_sfr_addr, `MIE_ST_LOW_ADDR);
  endsequence

  AST_FAULT_IRQ: assert property (s_fault_ev |=> o_metering_irq && st_r.st_low[5])
    else $error("fault change did not raise interrupt");
  AST_ACTIVE_SIGN: assert property (i_active_sign_change && st_r.en_low[3] && !wr_en_low
    |=> o_metering_irq)
    else $error("active sign change did not raise interrupt");
  AST_CALIB_TWO: assert property (i_calib_pulse_two && st_r.en_mid[7] && !wr_en_mid
    |=> o_metering_irq)
    else $error("second calibration pulse did not raise interrupt");
  AST_CALIB_FLAG: assert property (i_calib_pulse_one
    |=> st_r.st_mid[`MIE_CALIB_ONE_BIT])
    else $error("calibration flag missed a pulse");
  AST_OVERFLOW: assert property (i_reactive_energy_overflow && st_r.en_mid[4] && !wr_en_mid
    |=> o_metering_irq)
    else $error("energy overflow did not raise interrupt");
  AST_PEAK: assert property (i_voltage_peak_exceeded && st_r.en_high[3] && !wr_en_high
    |=> o_metering_irq)
    else $error("voltage peak did not raise interrupt");
  AST_ZERO_CROSS: assert property (i_zero_cross_detect && st_r.en_high[0] && !wr_en_high
    |=> o_metering_irq)
    else $error("zero crossing did not raise interrupt");
  AST_WAVE_HOLD: assert property (s_wave_hold ##1 s_wave_hold |=> o_metering_irq)
    else $error("waveform interrupt dropped before clear");
  AST_SUMMARY: assert property (s_sum_rd |=> o_sfr_rdata[`MIE_SUMMARY_BIT] == $past(o_metering_irq))
    else $error("summary bit differs from pending line");
  AST_GATING: assert property (o_metering_irq == (|(st_r.st_low & st_r.en_low)
    | |(st_r.st_mid & st_r.en_mid) | |(st_r.st_high & st_r.en_high)))
    else $error("interrupt not equal to enabled flags");
  AST_NO_EN: assert property ((st_r.en_low | st_r.en_mid | st_r.en_high) == 8'h00
    |-> !o_metering_irq)
    else $error("interrupt raised with nothing enabled");

endmodule

`default_nettype wire

/* mie_cpu_model.sv */
// processor core side model: issues sfr writes and reads
// assumes the block takes strobes on the rising edge and answers reads a cycle later
`timescale 1ns/1ps
`default_nettype none
module mie_cpu_model (
  // clock
  input wire logic i_core_clk,
  // sfr bus towards the block
  output logic [7:0] o_sfr_addr,
  output logic o_sfr_wr,
  output logic o_sfr_rd,
  output logic [7:0] o_sfr_wdata,
  input wire logic [7:0] i_sfr_rdata
);
  // bus idle at time zero
  initial begin
    o_sfr_addr = 8'h00;
    o_sfr_wr = 1'b0;
    o_sfr_rd = 1'b0;
    o_sfr_wdata = 8'h00;
  end
  // one write strobe held across a single rising edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_wdata = d;
    o_sfr_wr = 1'b1;
    @(negedge i_core_clk);
    o_sfr_wr = 1'b0;
    o_sfr_wdata = ~d; // released data must not look valid
  endtask
  // one read strobe; data is picked up in the following cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_sfr_addr = a;
    o_sfr_rd = 1'b1;
    @(negedge i_core_clk);
    d = i_sfr_rdata;
    o_sfr_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

/* mie_map.svh */
// register addresses, masks and reset values of the
// metering interrupt enable and status block
// assumes the includer sits in the core clock domain
`ifndef MIE_MAP_SVH
`define MIE_MAP_SVH

// enable registers in the sfr space
`define MIE_EN_LOW_ADDR 8'hD9
`define MIE_EN_MID_ADDR 8'hDA
`define MIE_EN_HIGH_ADDR 8'hDB

// status registers in the sfr space
`define MIE_ST_LOW_ADDR 8'hDC
`define MIE_ST_MID_ADDR 8'hDD
`define MIE_ST_HIGH_ADDR 8'hDE

// writable bits; the rest read as zero, save bit 7 of the first status register, which shows the summary bit, and bit 7 of the third, the end-of-reset flag
`define MIE_EN_LOW_MASK 8'h3F
`define MIE_EN_MID_MASK 8'hFF
`define MIE_EN_HIGH_MASK 8'h3F
`define MIE_ST_LOW_MASK 8'h3F
`define MIE_ST_HIGH_MASK 8'hBF

// reset values
`define MIE_EN_RST 8'h00
`define MIE_ST_RST 8'h00
`define MIE_ST_HIGH_RST 8'h80

// field positions
`define MIE_SUMMARY_BIT 7
`define MIE_CALIB_ONE_BIT 6
`define MIE_CALIB_TWO_BIT 7
`define MIE_WAVE_BIT 5

`endif

/* mie_pkg.sv */
// types of the metering interrupt enable block
// assumes mie_map.svh is compiled alongside
package mie_pkg;

  // whole register state of the block
  typedef struct packed {
    logic [7:0] en_low;  // enable, first register
    logic [7:0] en_mid;  // enable, second register
    logic [7:0] en_high; // enable, third register
    logic [7:0] st_low;  // flags, first register
    logic [7:0] st_mid;  // flags, second register
    logic [7:0] st_high; // flags, third register
    logic irq;           // pending interrupt
    logic [7:0] rdata;   // sfr read data
  } mie_state_t;

endpackage
